// *** spi_ctl_pkg.sv ***
package spi_ctl_pkg;
  // link engine states
  typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_DRAIN} eng_state_e;
  // register side state
  typedef struct packed {
    logic [31:0] ctrl;
    logic aud;
    logic [31:0] rdata;
    logic [31:0] txa;
    logic [31:0] txb;
    logic txa_v;
    logic txb_v;
    logic inflight;
    logic go_t;
    logic [31:0] rx;
    logic rx_full;
    logic ovf;
  } bus_state_s;
  // link side state
  typedef struct packed {
    eng_state_e st;
    logic sck;
    logic first;
    logic sprev;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [31:0] rx;
    logic [3:0] pend;
    logic done_t;
  } eng_state_s;
endpackage : spi_ctl_pkg

// *** spi_ctl_regs.svh ***
`ifndef SPI_CTL_REGS_SVH
`define SPI_CTL_REGS_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_TX 8'h08
`define OFS_RX 8'h0C
`define OFS_CTRL2 8'h10
// control field positions
`define B_DEEP 16
`define B_ON 15
`define B_GAP 14
`define B_HALT 13
`define B_RELO 12
`define B_WIDE 11
`define B_MID 10
`define B_SAMP 9
`define B_EDGE 8
`define B_SSUSE 7
`define B_CPOL 6
`define B_MAST 5
`define B_RELI 4
// second control field position
`define B_AUD 7
// status field positions
`define B_TXF 0
`define B_RXF 1
`define B_BUSY 2
`define B_OVF 3
// masks and reset value
`define CTRL_WMASK 32'h0001BFF0
`define REG_RST 32'h00000000
// word and channel widths in bits
`define W_8 6'h08
`define W_16 6'h10
`define W_24 6'h18
`define W_32 6'h20
`endif

// *** spi_ctl_top.sv ***
// What this block does
// R1: deep buffer enable gives a two-word transmit buffer; clear gives one word.
// R2: deep buffer enable only changes while the module is off.
// R3: module enable turns the serial port on when one, off when zero.
// R4: with halt-in-idle set, the port stops while the processor idles.
// R5: control bit next to enable is absent and reads zero.
// R6: release-data-out hands the data out pin to the port; else we drive.
// R7: audio width pairs give 24/32, 32/32, 16/32, 16/16 data/channel bits.
// R8: plain mode: wide select gives 32 bits, else mid select gives 16.
// R9: plain mode with both selects clear moves 8-bit words.
// R10: master samples input at end of output time when set, else middle.
// R11: slave ignores sample phase and always samples mid time.
// R12: output edge set: data changes active-to-idle; clear: idle-to-active.
// R13: software keeps output edge zero when framed mode is used.
// R14: slave with select use set watches the select pin; else port owns it.
// R15: polarity set: clock idles high; clear: idles low.
// R16: master role set generates the clock; clear makes the port a slave.
// R17: release-data-in leaves the data in pin unused by the port.
// R18: software avoids access in the cycle after clearing the enable.
// R19: audio enable selects audio widths; clear selects plain widths.
`timescale 1ns/1ps
`default_nettype none
`include "spi_ctl_regs.svh"
module spi_ctl_top #(
  parameter int ADDR_W = 8
) (
  // register clock domain
  input wire logic clock,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor power state
  input wire logic cpu_idle,
  // link clock domain
  input wire logic link_clock,
  input wire logic link_srst,
  // serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // serial data pins
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic sdi_in,
  // slave select pin, active low
  input wire logic ss_n_in,
  // pin ownership towards the port mux
  output logic sdo_pin_owned,
  output logic sdi_pin_owned,
  output logic ss_pin_owned
);
  // ==========================================================
  // declarations
  spi_ctl_pkg::bus_state_s q;
  spi_ctl_pkg::bus_state_s n;
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic rd_rx;
  logic done_now;
  logic active;
  logic tx_full;
  logic wide;
  logic mid;
  logic [5:0] data_bits;
  logic [5:0] chan_bits;
  logic [31:0] tx_al;
  logic [31:0] rx_al;
  logic samp_eff;
  logic [6:0] to_link;
  logic [6:0] at_link;
  logic [2:0] pins_s;
  logic [1:0] from_link;
  logic [1:0] at_bus;
  logic sdi_eff;
  logic eng_sck;
  logic eng_sdo;
  logic [31:0] eng_rx;
  logic eng_done;
  logic eng_busy;

  // ==========================================================
  // apb decode
  // zero wait states: read data is fetched in the setup cycle
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_STAT)
                  || (paddr == `OFS_TX) || (paddr == `OFS_RX)
                  || (paddr == `OFS_CTRL2);
  assign rd_rx = rd && (paddr == `OFS_RX);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = q.rdata;

  // ==========================================================
  // mode decode
  // idle only stops the port when halt-in-idle asks for it
  assign active = q.ctrl[`B_ON]
                  && !(q.ctrl[`B_HALT] && cpu_idle); // [R3] [R4]
  assign tx_full = q.ctrl[`B_DEEP] ? q.txb_v : q.txa_v; // [R1]
  assign wide = q.ctrl[`B_WIDE];
  assign mid = q.ctrl[`B_MID];
  // word width in plain mode, data width in audio mode
  assign data_bits = q.aud ? (wide ? (mid ? `W_24 : `W_32) : `W_16)
                   : (wide ? `W_32 : (mid ? `W_16 : `W_8)); // [R7] [R8] [R9]
  // bits clocked per word; audio keeps 32-bit channels unless both clear
  assign chan_bits = q.aud ? ((wide || mid) ? `W_32 : `W_16)
                   : data_bits; // [R19]
  // shifter sends msb first, so data sits at the top, padding after
  assign tx_al = q.txa << (`W_32 - data_bits);
  assign rx_al = eng_rx >> (chan_bits - data_bits);
  // slave role always samples at mid time
  assign samp_eff = q.ctrl[`B_MAST] && q.ctrl[`B_SAMP]; // [R10] [R11]

  // ==========================================================
  // register side state
  always_comb begin
    n = q;
    done_now = q.inflight && (at_bus[0] == q.go_t);
    // read data for the access phase
    if (setup && !pwrite) begin
      case (paddr)
        `OFS_CTRL: n.rdata = q.ctrl & `CTRL_WMASK; // [R5]
        `OFS_STAT: n.rdata = {28'h0000000, q.ovf, q.inflight,
                              q.rx_full, tx_full};
        `OFS_RX: n.rdata = q.rx;
        `OFS_CTRL2: n.rdata = {24'h000000, q.aud, 7'h00};
        default: n.rdata = `REG_RST;
      endcase
    end
    // control write; the unused position is masked off
    if (wr && (paddr == `OFS_CTRL)) begin
      n.ctrl = pwdata & `CTRL_WMASK; // [R3] [R5]
      if (q.ctrl[`B_ON]) begin
        n.ctrl[`B_DEEP] = q.ctrl[`B_DEEP]; // [R2]
      end
    end
    // audio select follows the same lock as the buffer mode
    if (wr && (paddr == `OFS_CTRL2) && !q.ctrl[`B_ON]) begin
      n.aud = pwdata[`B_AUD]; // [R19]
    end
    // clears come before sets so an arriving event wins
    if (rd_rx) begin
      n.rx_full = 1'b0;
    end
    if (wr && (paddr == `OFS_STAT) && pwdata[`B_OVF]) begin
      n.ovf = 1'b0;
    end
    // a finished word lands and the next slot moves up
    if (done_now) begin
      n.inflight = 1'b0;
      n.rx = rx_al;
      n.rx_full = 1'b1;
      if (q.rx_full && !rd_rx) begin
        n.ovf = 1'b1;
      end
      n.txa = q.txb;
      n.txa_v = q.txb_v;
      n.txb_v = 1'b0;
    end
    // start a word; txa stays frozen until the link answers
    if (!q.inflight && q.txa_v && active) begin
      n.go_t = ~q.go_t;
      n.inflight = 1'b1;
    end
    // transmit write: second slot exists only in deep mode
    if (wr && (paddr == `OFS_TX)) begin
      if (!n.txa_v) begin
        n.txa = pwdata;
        n.txa_v = 1'b1;
      end else if (q.ctrl[`B_DEEP] && !n.txb_v) begin
        n.txb = pwdata; // [R1]
        n.txb_v = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // domain crossing
  // config levels are static while a word runs; go is a toggle
  assign to_link = {active, q.ctrl[`B_MAST], q.ctrl[`B_CPOL],
                    q.ctrl[`B_EDGE], samp_eff, q.ctrl[`B_SSUSE],
                    q.go_t};

  spi_sync3 #(.W(7)) u_cfg_sync (
    .clk(link_clock),
    .rst(link_srst),
    .din(to_link),
    .dout(at_link)
  );

  // pins come from outside both clocks
  spi_sync3 #(.W(3)) u_pin_sync (
    .clk(link_clock),
    .rst(link_srst),
    .din({sck_in, ss_n_in, sdi_in}),
    .dout(pins_s)
  );

  // done toggle and busy return to the register side
  assign from_link = {eng_busy, eng_done};

  spi_sync3 #(.W(2)) u_ack_sync (
    .clk(clock),
    .rst(srst),
    .din(from_link),
    .dout(at_bus)
  );

  // a released input pin reads as zero to the shifter
  assign sdi_eff = q.ctrl[`B_RELI] ? 1'b0 : pins_s[0]; // [R17]

  // ==========================================================
  // link engine
  spi_link_engine u_engine (
    .link_clock(link_clock),
    .link_srst(link_srst),
    .run_en(at_link[6]),
    .go_t(at_link[0]),
    .master(at_link[5]),
    .cpol(at_link[4]),
    .out_edge(at_link[3]),
    .samp_end(at_link[2]),
    .ss_use(at_link[1]),
    .bits(chan_bits),
    .tx_word(tx_al),
    .sck_in(pins_s[2]),
    .ss_n_in(pins_s[1]),
    .sdi_in(sdi_eff),
    .sck_lvl(eng_sck),
    .sdo(eng_sdo),
    .rx_word(eng_rx),
    .done_t(eng_done),
    .busy(eng_busy)
  );

  // ==========================================================
  // pins
  // only a master drives the clock
  assign sck_out = eng_sck;
  assign sck_oe = active && q.ctrl[`B_MAST]; // [R16]
  assign sdo_out = eng_sdo;
  assign sdo_oe = active && !q.ctrl[`B_RELO]; // [R6]
  assign sdo_pin_owned = q.ctrl[`B_ON] && !q.ctrl[`B_RELO]; // [R6]
  assign sdi_pin_owned = q.ctrl[`B_ON] && !q.ctrl[`B_RELI]; // [R17]
  assign ss_pin_owned = q.ctrl[`B_ON] && !q.ctrl[`B_MAST]
                        && q.ctrl[`B_SSUSE]; // [R14]

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence ctrl_write_s;
    wr && (paddr == `OFS_CTRL);
  endsequence

  sequence rx_land_s;
    q.inflight && (at_bus[0] == q.go_t);
  endsequence

  deep_lock_a: assert property ( // [R2]
    ctrl_write_s and q.ctrl[`B_ON] |=> $stable(q.ctrl[`B_DEEP]))
    else $error("deep buffer changed while on");

  deep_take_a: assert property ( // [R1]
    ctrl_write_s and !q.ctrl[`B_ON]
    |=> q.ctrl[`B_DEEP] == $past(pwdata[`B_DEEP]))
    else $error("deep buffer write lost");

  enable_take_a: assert property ( // [R3]
    ctrl_write_s |=> q.ctrl[`B_ON] == $past(pwdata[`B_ON]) ##1
    (!q.ctrl[`B_ON] || q.ctrl[`B_HALT] && cpu_idle || active))
    else $error("enable not taken");

  gap_zero_a: assert property ( // [R5]
    rd && (paddr == `OFS_CTRL) |-> !prdata[`B_GAP])
    else $error("unused control bit read nonzero");

  idle_halt_a: assert property ( // [R4]
    q.ctrl[`B_HALT] && cpu_idle |-> !active && !sck_oe && !sdo_oe)
    else $error("port runs in idle");

  data_out_a: assert property ( // [R6]
    q.ctrl[`B_RELO] |-> !sdo_oe && !sdo_pin_owned)
    else $error("released data out still driven");

  audio_width_a: assert property ( // [R7]
    q.aud && wide && mid |-> data_bits == `W_24 && chan_bits == `W_32)
    else $error("audio width pair wrong");

  plain_width_a: assert property ( // [R8]
    !q.aud && wide |-> data_bits == `W_32 && chan_bits == `W_32)
    else $error("plain wide width wrong");

  byte_width_a: assert property ( // [R9]
    !q.aud && !wide && !mid |-> chan_bits == `W_8)
    else $error("plain byte width wrong");

  slave_samp_a: assert property ( // [R11]
    !q.ctrl[`B_MAST] |-> !samp_eff && !sck_oe)
    else $error("slave uses end sampling or drives clock");

  rx_wins_a: assert property (
    rx_land_s and rd_rx |=> q.rx_full ##1 $stable(q.rx) || rd_rx)
    else $error("arriving word lost to read clear");

endmodule : spi_ctl_top
`default_nettype wire

// *** spi_link_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_link_engine (
  // link clock domain
  input wire logic link_clock,
  input wire logic link_srst,
  // settled controls from the register side
  input wire logic run_en,
  input wire logic go_t,
  input wire logic master,
  input wire logic cpol,
  input wire logic out_edge,
  input wire logic samp_end,
  input wire logic ss_use,
  input wire logic [5:0] bits,
  input wire logic [31:0] tx_word,
  // settled pins
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic sdi_in,
  // results
  output logic sck_lvl,
  output logic sdo,
  output logic [31:0] rx_word,
  output logic done_t,
  output logic busy
);
  spi_ctl_pkg::eng_state_s q;
  spi_ctl_pkg::eng_state_s n;
  logic running;
  logic edge_s;
  logic sel;
  logic lead;
  logic trail;
  logic shift_ev;
  logic samp_ev;
  logic take;
  // clock transitions: made here as master, seen on the pin as slave
  assign running = (q.st == spi_ctl_pkg::ENG_RUN);
  assign edge_s = (sck_in != q.sprev);
  assign sel = !ss_use || !ss_n_in; // [R14]
  assign lead = master ? (running && (q.sck == cpol))
                       : (edge_s && (sck_in != cpol)); // [R15]
  assign trail = master ? (running && (q.sck != cpol))
                        : (edge_s && (sck_in == cpol));
  assign shift_ev = out_edge ? trail : (lead && !q.first); // [R12]
  // end sampling is only ever requested in master role upstream
  assign samp_ev = samp_end ? (out_edge ? trail : lead)
                            : (out_edge ? lead : trail); // [R10]
  // a master's own clock meets its returning data four link clocks late,
  // the depth of the pin synchroniser, so its sample points wait that long
  assign take = master ? q.pend[3] : samp_ev; // [R10] [R11]
  // next state
  always_comb begin
    n = q;
    n.sprev = sck_in;
    n.pend = {q.pend[2:0], master && samp_ev};
    if (take) begin
      n.rx = {q.rx[30:0], sdi_in};
    end
    case (q.st)
      spi_ctl_pkg::ENG_IDLE: begin
        n.sck = cpol; // [R15]
        if (run_en && (go_t != q.done_t) && (master || sel)) begin
          n.st = spi_ctl_pkg::ENG_RUN;
          n.sh = tx_word;
          n.cnt = 6'h00;
          n.first = 1'b1;
          n.rx = 32'h00000000;
        end
      end
      spi_ctl_pkg::ENG_RUN: begin
        if (master) begin
          n.sck = ~q.sck; // [R16]
        end
        if (shift_ev) begin
          n.sh = {q.sh[30:0], 1'b0};
        end
        if (lead) begin
          n.first = 1'b0;
        end
        if (samp_ev) begin
          n.cnt = q.cnt + 6'h01;
          if (q.cnt == bits - 6'h01) begin
            // the clock runs out its last transition; a master then drains
            if (master) begin
              n.st = spi_ctl_pkg::ENG_DRAIN;
            end else begin
              n.st = spi_ctl_pkg::ENG_IDLE;
              n.done_t = go_t;
            end
          end
        end
      end
      spi_ctl_pkg::ENG_DRAIN: begin
        n.sck = cpol; // [R15]
        if (q.pend[2:0] == 3'h0) begin
          n.st = spi_ctl_pkg::ENG_IDLE;
          n.done_t = go_t;
        end
      end
      default: n.st = spi_ctl_pkg::ENG_IDLE;
    endcase
    // switched off: close the handshake so the register side frees up
    if (!run_en) begin
      n.pend = 4'h0;
      n.st = spi_ctl_pkg::ENG_IDLE;
      n.done_t = go_t;
      n.sck = cpol;
    end
  end
  always_ff @(posedge link_clock) begin
    if (link_srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign sck_lvl = q.sck;
  assign sdo = q.sh[31];
  assign rx_word = q.rx;
  assign done_t = q.done_t;
  assign busy = (q.st != spi_ctl_pkg::ENG_IDLE);
  // idle clock level follows polarity
  idle_level_a: assert property (@(posedge link_clock) disable iff (link_srst)
    (q.st == spi_ctl_pkg::ENG_IDLE) && ($past(q.st) == spi_ctl_pkg::ENG_IDLE)
    |-> (q.sck == $past(cpol))) // [R15]
    else $error("idle clock level wrong");
  // output data moves on the chosen transition
  out_edge_a: assert property (@(posedge link_clock) disable iff (link_srst)
    master && running && ($past(q.st) == spi_ctl_pkg::ENG_RUN)
    && $changed(q.sh) |-> (q.sck == ($past(out_edge) ? cpol : ~cpol))) // [R12]
    else $error("output data changed on wrong edge");
endmodule : spi_link_engine
`default_nettype wire

// *** spi_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far-side serial peer, answering as a slave
module spi_peer (
  // serial pins
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  // setup from the bench
  input wire logic cpol,
  input wire logic out_edge,
  input wire logic load,
  input wire logic [31:0] word,
  // what the peer has seen
  output logic [31:0] cap,
  output var int nsamp
);
  logic [31:0] sh;
  // start quiet; the bench loads a word before every frame
  initial begin
    sdi = 1'b0;
    sh = 32'h0;
    cap = 32'h0;
    nsamp = 0;
  end
  // load restarts a frame; each clock edge samples or, once a sample is taken, shifts
  always @(posedge load or sck) begin
    if (load) begin
      sh = word;
      sdi = word[31];
      cap = 32'h0;
      nsamp = 0;
    end else if ((sck != cpol) == out_edge) begin
      cap = {cap[30:0], sdo};
      nsamp = nsamp + 1;
    end else if (nsamp > 0) begin
      // no shift before the first sample, so the msb is not skipped
      sh = {sh[30:0], 1'b0};
      sdi = sh[31];
    end
  end
endmodule : spi_peer
`default_nettype wire

// *** spi_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_sync3 #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst,
  // foreign levels in, settled levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [W-1:0] c;
    logic [W-1:0] o;
  } sync_s;
  sync_s q;
  sync_s n;
  // the first stage feeds only the second; output moves when 2 and 3 agree
  always_comb begin
    n = q;
    n.a = din;
    n.b = q.a;
    n.c = q.b;
    n.o = ((q.b ~^ q.c) & q.c) | ((q.b ^ q.c) & q.o);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign dout = q.o;
endmodule : spi_sync3
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spi_ctl_regs.svh"
// ==========================================
// bench for the serial port control block
module tb_top;
  // clocks, resets and stimulus
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic srst = 1'b1;
  logic link_srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cpu_idle = 1'b0;
  logic load = 1'b0;
  logic ppol = 1'b0;
  logic pedge = 1'b0;
  logic [31:0] peer_word = 32'h0;
  // observed outputs
  logic [31:0] prdata;
  logic [31:0] cap;
  logic pready, pslverr, sck_out, sck_oe, sdo_out, sdo_oe, sdi_in;
  logic sdo_own, sdi_own, ss_own;
  int nsamp;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 12;
  // register clock, and a link clock with an unrelated phase
  always #4 clock = ~clock;
  initial begin
    #13;
    forever #40 link_clock = ~link_clock;
  end
  // ==========================================
  // design and peer
  spi_ctl_top DUT (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
    .link_clock(link_clock), .link_srst(link_srst), .sck_in(1'b0),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sdi_in(sdi_in), .ss_n_in(1'b1),
    .sdo_pin_owned(sdo_own), .sdi_pin_owned(sdi_own),
    .ss_pin_owned(ss_own)
  );
  spi_peer peer (
    .sck(sck_out), .sdo(sdo_out), .sdi(sdi_in), .cpol(ppol),
    .out_edge(pedge), .load(load), .word(peer_word), .cap(cap),
    .nsamp(nsamp)
  );
  // ==========================================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic give_up();
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    final_report();
  endtask : give_up
  // ==========================================
  // apb master: request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 50) give_up();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  // wait until the peer has seen n bits, then let the word land
  task automatic wait_bits(input int n);
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge clock);
      if (nsamp >= n) break;
    end
    if (i == 4000) give_up();
    repeat (40) @(posedge clock);
  endtask : wait_bits
  // ==========================================
  // one master word in a given width mode, clock polarity, output edge and sample phase random
  task automatic xfer(input logic aud, input logic wide, input logic mid);
    logic [31:0] tx, q, ctl;
    longint ex;
    int db, cb, i;
    q = $random(seed);
    tx = $random(seed);
    // width table model: data bits and channel bits
    if (aud) begin
      db = wide ? (mid ? 24 : 32) : 16;
      cb = (wide || mid) ? 32 : 16;
    end else begin
      db = wide ? 32 : (mid ? 16 : 8);
      cb = db;
    end
    ctl = 32'hA020 ^ 32'h2000 | (32'(wide) << 11) | (32'(mid) << 10)
        | (32'(q[1] & q[2]) << 9) | (32'(q[1]) << 8) | (32'(q[0]) << 6);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_CTRL2, 32'(aud) << 7);
    wr(`OFS_CTRL, ctl);
    // peer setup settles well before load samples it
    ppol <= q[0];
    pedge <= q[1];
    peer_word <= $random(seed);
    // let the new idle level cross before the peer starts listening
    repeat (80) @(posedge clock);
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    wr(`OFS_TX, tx);
    wait_bits(cb);
    for (i = 0; i < 20; i++) begin
      rd(`OFS_STAT, q);
      if (q[`B_RXF] === 1'b1) break;
    end
    if (i == 20) give_up();
    rd(`OFS_RX, q);
    chk(q, peer_word >> (32 - db), "rx data");
    ex = (longint'(tx) & ((64'h1 << db) - 1)) << (cb - db);
    chk(cap, ex[31:0], "tx data");
    chk(32'(nsamp), 32'(cb), "bit count");
    chk({31'h0, sck_out}, {31'h0, ctl[6]}, "idle level");
  endtask : xfer
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] q, d;
    logic e;
    int k;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    link_srst <= 1'b0;
    rd(`OFS_CTRL, q);
    chk(q, `REG_RST, "ctrl reset");
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    // random control words; deep bit must hold while enabled
    repeat (6) begin
      d = $random(seed) & ~32'h8000;
      wr(`OFS_CTRL, d);
      rd(`OFS_CTRL, q);
      chk(q, d & `CTRL_WMASK, "ctrl readback");
      wr(`OFS_CTRL, d | 32'h8000);
      wr(`OFS_CTRL, d ^ 32'h18000);
      rd(`OFS_CTRL, q);
      chk(q, (d | 32'h8000) & `CTRL_WMASK, "deep locked");
      chk({27'h0, sck_oe, sdo_oe, sdo_own, sdi_own, ss_own},
          {27'h0, d[5], ~d[12], ~d[12], ~d[4], ~d[5] & d[7]},
          "owners");
      wr(`OFS_CTRL, 32'h0);
    end
    // single then deep buffer, halted while the processor idles
    pedge <= 1'b1; // peer follows the output edge set below
    for (k = 0; k < 2; k++) begin
      cpu_idle <= 1'b1;
      load <= 1'b1;
      wr(`OFS_CTRL, 32'h2120 | (32'(k) << 16));
      load <= 1'b0;
      wr(`OFS_CTRL, 32'hA120 | (32'(k) << 16));
      wr(`OFS_TX, 32'h000000A5);
      rd(`OFS_STAT, q);
      chk({31'h0, q[`B_TXF]}, 32'(1 - k), "tx full");
      wr(`OFS_TX, 32'h0000003C);
      repeat (40) @(posedge clock);
      chk(32'(nsamp), 32'h0, "halted");
      cpu_idle <= 1'b0;
      wait_bits(8 * (k + 1));
      chk(32'(nsamp), 32'(8 * (k + 1)), "words sent");
      chk(cap, k ? 32'h0000A53C : 32'h000000A5, "sent data");
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_STAT, 32'h8);
      rd(`OFS_RX, q);
    end
    // every width pair, audio off and on
    for (k = 0; k < 8; k++) begin
      xfer(k[2], k[1], k[0]);
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
